// [bench/tlp_cpu_model.sv]
// Purpose: CPU core model that takes vectored long calls and returns.
// Assumes: Acknowledge is a one-cycle pulse; slow mode waits four cycles.
// Notes: Records the last call taken for the bench to judge.
`timescale 1ns/1ps
module tlp_cpu_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic long_call_req,
	input wire logic [2:0] long_call_source,
	input wire logic long_call_high,
	input wire logic long_call_push_pc_only,
	input wire logic slow,
	input wire logic ret_go,
	output logic long_call_ack,
	output logic service_return,
	output logic [2:0] took_source,
	output logic took_high,
	output logic took_pc_only,
	output int took_count
);
	logic [1:0] wait_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			long_call_ack <= 1'b0;
			wait_reg <= 2'h0;
		end else if (long_call_req && !long_call_ack) begin
			wait_reg <= wait_reg + 2'h1;
			long_call_ack <= !slow || (wait_reg == 2'h3);
		end else begin
			long_call_ack <= 1'b0;
			wait_reg <= 2'h0;
		end
	end
	// The core saves nothing but the program counter; that marker is kept with the source and level of each call.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			took_count <= 0;
			service_return <= 1'b0;
		end else begin
			service_return <= ret_go;
			if (long_call_req && long_call_ack) begin
				took_source <= long_call_source;
				took_high <= long_call_high;
				took_pc_only <= long_call_push_pc_only;
				took_count <= took_count + 1;
			end
		end
	end
endmodule : tlp_cpu_model

// [bench/tlp_int_priority_monitor.sv]
// Purpose: Port-level checker for the two-level interrupt priority unit.
// Assumes: Bound to tlp_int_priority; sees only its ports.
// Notes: Call decisions are judged from request, acknowledge and service levels.
`timescale 1ns/1ps
module tlp_int_priority_monitor
	import tlp_pkg::*;
#(
	parameter int MACHINE_CYCLE_CLKS = MC_CLKS
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic watchdog_timer_reset,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic global_int_enable,
	input wire logic long_call_req,
	input wire logic long_call_high,
	input wire logic long_call_push_pc_only,
	input wire logic long_call_ack,
	input wire logic in_service_high,
	input wire logic in_service_low
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_taken;
		long_call_req && long_call_ack && !watchdog_timer_reset;
	endsequence
	sequence s_waiting;
		long_call_req && !long_call_ack && !watchdog_timer_reset;
	endsequence
	a_req_holds: assert property (s_waiting |=> long_call_req)
		else $error("call request dropped before acknowledge");
	a_ack_drops_req: assert property (s_taken |=> !long_call_req)
		else $error("call request still high after acknowledge");
	a_push_pc_only: assert property (long_call_push_pc_only == long_call_req)
		else $error("push marker differs from call request");
	a_high_blocks_all: assert property ($rose(long_call_req) |->
		!($past(in_service_high) && $past(in_service_high, 2)))
		else $error("call raised during high service");
	a_low_blocks_low: assert property ($rose(long_call_req) && $past(in_service_low)
		&& $past(in_service_low, 2) |-> long_call_high)
		else $error("low call raised during low service");
	a_global_gate: assert property (!global_int_enable [*3] |=> !$rose(long_call_req))
		else $error("call raised with global enable low");
	a_ack_enters: assert property (s_taken |=>
		($past(long_call_high) ? in_service_high : in_service_low))
		else $error("acknowledge did not enter service level");
	a_wdt_clears: assert property (watchdog_timer_reset |=>
		!long_call_req && !in_service_high && !in_service_low)
		else $error("watchdog reset left call state");
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
endmodule : tlp_int_priority_monitor

bind tlp_int_priority tlp_int_priority_monitor #(
	.MACHINE_CYCLE_CLKS(MACHINE_CYCLE_CLKS)
) u_monitor (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.watchdog_timer_reset(watchdog_timer_reset),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.global_int_enable(global_int_enable),
	.long_call_req(long_call_req),
	.long_call_high(long_call_high),
	.long_call_push_pc_only(long_call_push_pc_only),
	.long_call_ack(long_call_ack),
	.in_service_high(in_service_high),
	.in_service_low(in_service_low)
);

// [bench/tlp_int_priority_test.sv]
// Purpose: Self-checking bench for the two-level interrupt priority unit.
// Assumes: One machine cycle per clock to keep waits short.
// Notes: Register port is driven directly; the CPU side is a model.
`timescale 1ns/1ps
module tlp_int_priority_test;
	import tlp_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic wdt = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic gie = 1'b0;
	logic idle = 1'b0;
	logic fault = 1'b0;
	logic wake = 1'b0;
	logic rsm = 1'b1;
	logic bt_a = 1'b0;
	logic bt_b = 1'b0;
	logic ext_a = 1'b1;
	logic ext_b = 1'b1;
	logic spi_done = 1'b0;
	logic spi_fault = 1'b0;
	logic slow = 1'b0;
	logic ret_go = 1'b0;
	logic [7:0] src_en = 8'hFF;
	logic req, high, pc_only, ack, svc_ret, took_high, took_pc, ish, isl;
	logic [2:0] src, took_src;
	int took_count;
	int num_errors = 0;
	int checks_done = 0;
	always #10 clk_sys = ~clk_sys;
	tlp_int_priority #(.MACHINE_CYCLE_CLKS(1)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.watchdog_timer_reset(wdt), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_int_enable(gie),
		.source_enable(src_en), .idle_mode(idle), .invalid_address_fault(fault),
		.wake_timer_overflow(wake), .port_resume_pin(rsm), .base_timer_a_overflow(bt_a),
		.base_timer_b_overflow(bt_b), .ext_int_a_pin(ext_a), .ext_int_b_pin(ext_b),
		.spi_transfer_done_flag(spi_done), .spi_mode_fault_flag(spi_fault),
		.long_call_req(req), .long_call_source(src), .long_call_high(high),
		.long_call_push_pc_only(pc_only), .long_call_ack(ack), .service_return(svc_ret),
		.in_service_high(ish), .in_service_low(isl));
	tlp_cpu_model cpu (.clk_sys(clk_sys), .rst_n(rst_n), .long_call_req(req),
		.long_call_source(src), .long_call_high(high), .long_call_push_pc_only(pc_only),
		.slow(slow), .ret_go(ret_go), .long_call_ack(ack), .service_return(svc_ret),
		.took_source(took_src), .took_high(took_high), .took_pc_only(took_pc),
		.took_count(took_count));
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		v = reg_rdata;
		@(posedge clk_sys);
	endtask : rd
	task automatic flags(input logic [7:0] exp);
		logic [7:0] v;
		rd(OFS_REQUEST_FLAGS, v);
		check(v, exp);
	endtask : flags
	task automatic wait_call(input logic [2:0] s, input logic h);
		int c0;
		c0 = took_count;
		for (int i = 0; i < 60 && took_count == c0; i++) @(posedge clk_sys);
		if (took_count == c0) begin
			num_errors++;
			$display("ERROR at %0t: no call taken", $time);
			summarize();
		end else begin
			check({3'h0, took_pc, took_high, took_src}, {3'h0, 1'b1, h, s});
			check({7'h0, (h ? ish : isl)}, 8'h01);
		end
	endtask : wait_call
	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) @(negedge clk_sys) seen = seen | (req !== 1'b0);
		@(posedge clk_sys);
		check({7'h0, seen}, 8'h00);
	endtask : quiet
	task automatic ret;
		@(posedge clk_sys);
		ret_go <= 1'b1;
		@(posedge clk_sys);
		ret_go <= 1'b0;
		tick(2);
	endtask : ret
	task automatic t_regs;
		logic [7:0] v;
		logic [7:0] a [6] = '{8'h97, 8'hB8, 8'hB9, 8'hD9, 8'hDA, 8'h00};
		logic [7:0] m [6] = '{8'h03, 8'h7F, 8'h01, 8'h03, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rd(a[i], v);
			check(v, 8'h00);
			wr(a[i], 8'hFF);
			rd(a[i], v);
			check(v, m[i]);
		end
		@(posedge clk_sys);
		wdt <= 1'b1;
		@(posedge clk_sys);
		wdt <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(a[i], v);
			check(v, 8'h00);
		end
		$display("register test done");
	endtask : t_regs
	task automatic t_flags;
		@(posedge clk_sys);
		{bt_a, bt_b, fault, wake} <= 4'hF;
		@(posedge clk_sys);
		{bt_a, bt_b, fault, wake} <= 4'h0;
		flags(8'h4C);
		idle <= 1'b1;
		wake <= 1'b1;
		@(posedge clk_sys);
		wake <= 1'b0;
		flags(8'h6C);
		wr(OFS_REQUEST_FLAGS, 8'hF3);
		flags(8'h60);
		wr(OFS_REQUEST_FLAGS, 8'h00);
		idle <= 1'b0;
		flags(8'h00);
		{ext_a, ext_b} <= 2'b00;
		flags(8'h03);
		wr(OFS_REQUEST_FLAGS, 8'h00);
		flags(8'h00);
		wr(OFS_EXT_TRIGGER_TYPE, 8'h03);
		wr(OFS_REQUEST_FLAGS, 8'h00);
		flags(8'h03);
		{ext_a, ext_b} <= 2'b11;
		wr(OFS_EXT_TRIGGER_TYPE, 8'h00);
		wr(OFS_REQUEST_FLAGS, 8'h00);
		flags(8'h00);
		$display("flag test done");
	endtask : t_flags
	task automatic t_resume;
		logic [7:0] v;
		logic exp;
		for (int m = 0; m < 4; m++) begin
			wr(OFS_RESUME_TRIGGER_SELECT, 8'(m));
			for (int ph = 0; ph < 2; ph++) begin
				// Phase one ends on a falling edge, phase zero on a rising one.
				exp = (ph == 1) ? (m != 1) : (m != 2);
				idle <= 1'b0;
				rsm <= ph[0];
				tick(3);
				wr(OFS_REQUEST_FLAGS, 8'h00);
				idle <= 1'b1;
				tick(3);
				rsm <= !ph[0];
				tick(4);
				rd(OFS_REQUEST_FLAGS, v);
				check({7'h0, v[4]}, {7'h0, exp});
			end
		end
		idle <= 1'b0;
		rsm <= 1'b1;
		wr(OFS_RESUME_TRIGGER_SELECT, 8'h00);
		wr(OFS_REQUEST_FLAGS, 8'h00);
		$display("resume test done");
	endtask : t_resume
	task automatic t_prio;
		slow <= 1'b1;
		wr(OFS_PRIORITY_SELECT_MAIN, 8'h04);
		@(posedge clk_sys);
		{bt_a, bt_b} <= 2'b11;
		@(posedge clk_sys);
		{bt_a, bt_b} <= 2'b00;
		quiet(12);
		gie <= 1'b1;
		wait_call(3'd2, 1'b1);
		quiet(8);
		ret();
		wait_call(3'd3, 1'b0);
		flags(8'h00);
		@(posedge clk_sys);
		bt_b <= 1'b1;
		@(posedge clk_sys);
		bt_b <= 1'b0;
		quiet(8);
		bt_a <= 1'b1;
		@(posedge clk_sys);
		bt_a <= 1'b0;
		wait_call(3'd2, 1'b1);
		ret();
		quiet(6);
		ret();
		wait_call(3'd3, 1'b0);
		ret();
		$display("priority test done");
	endtask : t_prio
	task automatic t_poll;
		slow <= 1'b0;
		wr(OFS_PRIORITY_SELECT_MAIN, 8'h00);
		@(posedge clk_sys);
		{bt_a, bt_b, ext_a} <= 3'b110;
		@(posedge clk_sys);
		// The serial port request is a live level while the other flags are
		// stored, so it rises one cycle later to land in the same sample.
		{bt_a, bt_b, spi_fault} <= 3'b001;
		wait_call(3'd0, 1'b0);
		ret();
		wait_call(3'd2, 1'b0);
		ret();
		wait_call(3'd3, 1'b0);
		ret();
		wait_call(3'd7, 1'b0);
		{spi_fault, ext_a} <= 2'b01;
		ret();
		wr(OFS_PRIORITY_SELECT_EXT, 8'h01);
		spi_done <= 1'b1;
		wait_call(3'd7, 1'b1);
		spi_done <= 1'b0;
		ret();
		wr(OFS_PRIORITY_SELECT_MAIN, 8'h40);
		fault <= 1'b1;
		@(posedge clk_sys);
		fault <= 1'b0;
		wait_call(3'd6, 1'b1);
		flags(8'h40);
		wr(OFS_REQUEST_FLAGS, 8'h00);
		ret();
		quiet(6);
		src_en <= 8'hFB;
		bt_a <= 1'b1;
		@(posedge clk_sys);
		bt_a <= 1'b0;
		quiet(6);
		src_en <= 8'hFF;
		wait_call(3'd2, 1'b0);
		ret();
		$display("polling test done");
	endtask : t_poll
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs();
		t_flags();
		t_resume();
		t_prio();
		t_poll();
		summarize();
	end
endmodule : tlp_int_priority_test

// [core/tlp_fixed_arbiter.sv]
// Purpose: Fixed-order picker; the lowest set request index wins.
// Assumes: Purely combinational.
// Notes: Used once per priority level.
`timescale 1ns/1ps
module tlp_fixed_arbiter #(
	parameter int N = 8,
	parameter int W = 3
) (
	input wire logic [N-1:0] req,
	output logic found,
	output logic [W-1:0] idx
);

	always_comb begin
		found = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				idx = W'(i);
			end
		end
	end

endmodule : tlp_fixed_arbiter

// [core/tlp_int_priority.sv]
// Purpose: Two-level interrupt priority, request flags and trigger selection.
// Assumes: Event inputs are synchronous pulses or levels on clk_sys.
// Notes: The CPU acknowledges a long call and signals each service return.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module tlp_int_priority
	import tlp_pkg::*;
#(
	parameter int MACHINE_CYCLE_CLKS = MC_CLKS
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic watchdog_timer_reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic global_int_enable,
	input wire logic [7:0] source_enable,
	input wire logic idle_mode,
	input wire logic invalid_address_fault,
	input wire logic wake_timer_overflow,
	input wire logic port_resume_pin,
	input wire logic base_timer_a_overflow,
	input wire logic base_timer_b_overflow,
	input wire logic ext_int_a_pin,
	input wire logic ext_int_b_pin,
	input wire logic spi_transfer_done_flag,
	input wire logic spi_mode_fault_flag,
	output logic long_call_req,
	output logic [2:0] long_call_source,
	output logic long_call_high,
	output logic long_call_push_pc_only,
	input wire logic long_call_ack,
	input wire logic service_return,
	output logic in_service_high,
	output logic in_service_low
);

	// ****************************************************************
	// Registers and internal signals
	// ****************************************************************
	logic [7:0] resume_trigger_select_reg;
	logic [7:0] priority_select_main_reg;
	logic [7:0] priority_select_ext_reg;
	logic [7:0] ext_trigger_type_reg;
	logic [7:0] request_flags_reg;
	logic [7:0] request_flags_next;
	logic [7:0] sample_reg;
	logic [7:0] mc_count_reg;
	logic mc_tick;
	logic sample_valid_reg;
	tlp_call_state_t call_state_reg;
	logic fire_ext_a;
	logic fire_ext_b;
	logic fire_resume;
	logic [1:0] ext_a_mode;
	logic [1:0] ext_b_mode;
	logic [7:0] pending;
	logic [7:0] level_high;
	logic [7:0] req_high;
	logic [7:0] req_low;
	logic found_high;
	logic found_low;
	logic [2:0] idx_high;
	logic [2:0] idx_low;
	logic win_valid;
	logic [2:0] win_idx;
	logic win_high;
	logic wr_hit_flags;
	logic [7:0] set_events;
	logic [7:0] auto_clear;
	logic [7:0] read_mux;

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// The watchdog reset is a synchronous pulse so that the asynchronous
	// reset path only ever loads constants.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			priority_select_main_reg <= RST_PRIORITY_SELECT_MAIN;
			priority_select_ext_reg <= RST_PRIORITY_SELECT_EXT;
			ext_trigger_type_reg <= RST_EXT_TRIGGER_TYPE;
			resume_trigger_select_reg <= RST_RESUME_TRIGGER_SELECT;
		end else if (watchdog_timer_reset) begin
			priority_select_main_reg <= RST_PRIORITY_SELECT_MAIN;
			priority_select_ext_reg <= RST_PRIORITY_SELECT_EXT;
			ext_trigger_type_reg <= RST_EXT_TRIGGER_TYPE;
			resume_trigger_select_reg <= RST_RESUME_TRIGGER_SELECT;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_PRIORITY_SELECT_MAIN: begin
					priority_select_main_reg <= reg_wdata & MASK_PRIORITY_MAIN;
				end
				OFS_PRIORITY_SELECT_EXT: begin
					priority_select_ext_reg <= reg_wdata & MASK_PRIORITY_EXT;
				end
				OFS_EXT_TRIGGER_TYPE: begin
					ext_trigger_type_reg <= reg_wdata & MASK_EXT_TRIGGER_TYPE;
				end
				OFS_RESUME_TRIGGER_SELECT: begin
					resume_trigger_select_reg <= reg_wdata & MASK_RESUME_TRIGGER;
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// Trigger detection
	// ****************************************************************
	assign ext_a_mode = ext_trigger_type_reg[BIT_EXT_INT_A] ? TRIG_LOW_LEVEL : TRIG_FALLING;
	assign ext_b_mode = ext_trigger_type_reg[BIT_EXT_INT_B] ? TRIG_LOW_LEVEL : TRIG_FALLING;

	tlp_trigger_detect u_det_ext_a (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.mode(ext_a_mode),
		.pin(ext_int_a_pin),
		.fire(fire_ext_a)
	);

	tlp_trigger_detect u_det_ext_b (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.mode(ext_b_mode),
		.pin(ext_int_b_pin),
		.fire(fire_ext_b)
	);

	tlp_trigger_detect u_det_resume (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.mode(resume_trigger_select_reg[1:0]),
		.pin(port_resume_pin),
		.fire(fire_resume)
	);

	// ****************************************************************
	// Request flags
	// ****************************************************************
	always_comb begin
		set_events = 8'h00;
		set_events[BIT_ADDR_FAULT] = invalid_address_fault;
		set_events[BIT_WAKE_TIMER] = wake_timer_overflow & idle_mode;
		set_events[BIT_PORT_RESUME] = fire_resume & idle_mode;
		set_events[BIT_BASE_TIMER_B] = base_timer_b_overflow;
		set_events[BIT_BASE_TIMER_A] = base_timer_a_overflow;
		set_events[BIT_EXT_INT_B] = fire_ext_b;
		set_events[BIT_EXT_INT_A] = fire_ext_a;
	end

	assign wr_hit_flags = reg_wr && (reg_addr == OFS_REQUEST_FLAGS);

	// The address fault flag is never cleared by the acknowledge.
	always_comb begin
		auto_clear = 8'h00;
		if (long_call_req && long_call_ack && (long_call_source != 3'(BIT_ADDR_FAULT))) begin
			auto_clear[long_call_source] = 1'b1;
		end
	end

	// Hardware sets win over software and acknowledge clears, which also
	// keeps a held-low level pin requesting after its vector is taken.
	always_comb begin
		request_flags_next = request_flags_reg & ~auto_clear;
		if (wr_hit_flags) begin
			request_flags_next = request_flags_next & reg_wdata;
		end
		request_flags_next = (request_flags_next | set_events) & MASK_REQUEST_FLAGS;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			request_flags_reg <= RST_REQUEST_FLAGS;
		end else if (watchdog_timer_reset) begin
			request_flags_reg <= RST_REQUEST_FLAGS;
		end else begin
			request_flags_reg <= request_flags_next;
		end
	end

	// ****************************************************************
	// Machine cycle sampling
	// ****************************************************************
	assign mc_tick = (mc_count_reg == 8'(MACHINE_CYCLE_CLKS - 1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mc_count_reg <= 8'h00;
		end else if (mc_tick) begin
			mc_count_reg <= 8'h00;
		end else begin
			mc_count_reg <= mc_count_reg + 8'h01;
		end
	end

	always_comb begin
		pending = request_flags_reg;
		pending[BIT_SERIAL_PORT] = spi_transfer_done_flag | spi_mode_fault_flag;
	end

	// Flags are latched at one tick and judged at the next, so a request
	// needs up to two machine cycles before a call is raised.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sample_reg <= 8'h00;
			sample_valid_reg <= 1'b0;
		end else if (watchdog_timer_reset) begin
			sample_reg <= 8'h00;
			sample_valid_reg <= 1'b0;
		end else if (mc_tick) begin
			sample_reg <= pending & source_enable;
			sample_valid_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// Arbitration
	// ****************************************************************
	always_comb begin
		level_high = priority_select_main_reg & MASK_PRIORITY_MAIN;
		level_high[BIT_SERIAL_PORT] = priority_select_ext_reg[BIT_SERIAL_PORT_PRIORITY];
	end

	// Sampled flags are split into high and low requests by the priority
	// select bits; the hold state keeps taken flags from being re-polled.
	assign req_high = sample_reg & level_high;
	assign req_low = sample_reg & ~level_high;

	tlp_fixed_arbiter #(
		.N(NUM_SOURCES),
		.W(3)
	) u_arb_high (
		.req(req_high),
		.found(found_high),
		.idx(idx_high)
	);

	tlp_fixed_arbiter #(
		.N(NUM_SOURCES),
		.W(3)
	) u_arb_low (
		.req(req_low),
		.found(found_low),
		.idx(idx_low)
	);

	always_comb begin
		win_valid = 1'b0;
		win_idx = 3'h0;
		win_high = 1'b0;
		if (!global_int_enable || in_service_high) begin
			win_valid = 1'b0;
		end else if (found_high) begin
			win_valid = 1'b1;
			win_idx = idx_high;
			win_high = 1'b1;
		end else if (found_low && !in_service_low) begin
			win_valid = 1'b1;
			win_idx = idx_low;
		end
	end

	// ****************************************************************
	// Long call sequencing
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			call_state_reg <= TLP_IDLE;
			long_call_req <= 1'b0;
			long_call_source <= 3'h0;
			long_call_high <= 1'b0;
			long_call_push_pc_only <= 1'b0;
		end else if (watchdog_timer_reset) begin
			call_state_reg <= TLP_IDLE;
			long_call_req <= 1'b0;
			long_call_push_pc_only <= 1'b0;
		end else begin
			case (call_state_reg)
				TLP_IDLE: begin
					if (mc_tick && sample_valid_reg && win_valid) begin
						call_state_reg <= TLP_CALL;
						long_call_req <= 1'b1;
						long_call_source <= win_idx;
						long_call_high <= win_high;
						long_call_push_pc_only <= 1'b1;
					end
				end
				TLP_CALL: begin
					if (long_call_ack) begin
						call_state_reg <= TLP_HOLD;
						long_call_req <= 1'b0;
						long_call_push_pc_only <= 1'b0;
					end
				end
				TLP_HOLD: begin
					// One machine cycle must pass so the stale sample is replaced.
					if (mc_tick) begin
						call_state_reg <= TLP_IDLE;
					end
				end
				default: begin
					call_state_reg <= TLP_IDLE;
					long_call_req <= 1'b0;
					long_call_push_pc_only <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// In-service tracking
	// ****************************************************************
	// A return closes the innermost routine: high if active, else low.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			in_service_high <= 1'b0;
			in_service_low <= 1'b0;
		end else if (watchdog_timer_reset) begin
			in_service_high <= 1'b0;
			in_service_low <= 1'b0;
		end else if (long_call_req && long_call_ack) begin
			if (long_call_high) begin
				in_service_high <= 1'b1;
			end else begin
				in_service_low <= 1'b1;
			end
		end else if (service_return) begin
			if (in_service_high) begin
				in_service_high <= 1'b0;
			end else begin
				in_service_low <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	always_comb begin
		case (reg_addr)
			OFS_PRIORITY_SELECT_MAIN: read_mux = priority_select_main_reg;
			OFS_PRIORITY_SELECT_EXT: read_mux = priority_select_ext_reg;
			OFS_EXT_TRIGGER_TYPE: read_mux = ext_trigger_type_reg;
			OFS_RESUME_TRIGGER_SELECT: read_mux = resume_trigger_select_reg;
			OFS_REQUEST_FLAGS: read_mux = request_flags_reg;
			default: read_mux = 8'h00;
		endcase
	end

	// Read data stand for exactly one cycle and are zero otherwise.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= read_mux;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule : tlp_int_priority

// [core/tlp_pkg.sv]
// Purpose: Shared constants for the two-level interrupt priority unit.
// Assumes: 8-bit register port, byte offsets as printed.
// Notes: Source bit positions are shared by priority, flag and enable vectors.
package tlp_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_RESUME_TRIGGER_SELECT = 8'h97;
	localparam logic [7:0] OFS_PRIORITY_SELECT_MAIN = 8'hB8;
	localparam logic [7:0] OFS_PRIORITY_SELECT_EXT = 8'hB9;
	localparam logic [7:0] OFS_EXT_TRIGGER_TYPE = 8'hD9;
	localparam logic [7:0] OFS_REQUEST_FLAGS = 8'hDA;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_RESUME_TRIGGER_SELECT = 8'h00;
	localparam logic [7:0] RST_PRIORITY_SELECT_MAIN = 8'h00;
	localparam logic [7:0] RST_PRIORITY_SELECT_EXT = 8'h00;
	localparam logic [7:0] RST_EXT_TRIGGER_TYPE = 8'h00;
	localparam logic [7:0] RST_REQUEST_FLAGS = 8'h00;

	// ****************************************************************
	// Field positions and masks
	// ****************************************************************
	localparam int BIT_EXT_INT_A = 0;
	localparam int BIT_EXT_INT_B = 1;
	localparam int BIT_BASE_TIMER_A = 2;
	localparam int BIT_BASE_TIMER_B = 3;
	localparam int BIT_PORT_RESUME = 4;
	localparam int BIT_WAKE_TIMER = 5;
	localparam int BIT_ADDR_FAULT = 6;
	localparam int BIT_SERIAL_PORT = 7;
	localparam int BIT_SERIAL_PORT_PRIORITY = 0;
	localparam logic [7:0] MASK_PRIORITY_MAIN = 8'h7F;
	localparam logic [7:0] MASK_PRIORITY_EXT = 8'h01;
	localparam logic [7:0] MASK_REQUEST_FLAGS = 8'h7F;
	localparam logic [7:0] MASK_EXT_TRIGGER_TYPE = 8'h03;
	localparam logic [7:0] MASK_RESUME_TRIGGER = 8'h03;

	// ****************************************************************
	// Trigger modes and timing
	// ****************************************************************
	localparam logic [1:0] TRIG_LOW_LEVEL = 2'h0;
	localparam logic [1:0] TRIG_RISING = 2'h1;
	localparam logic [1:0] TRIG_FALLING = 2'h2;
	localparam logic [1:0] TRIG_BOTH = 2'h3;
	localparam int NUM_SOURCES = 8;
	localparam int MC_CLKS = 4;

	typedef enum logic [2:0] {
		TLP_IDLE = 3'b001,
		TLP_CALL = 3'b010,
		TLP_HOLD = 3'b100
	} tlp_call_state_t;

endpackage : tlp_pkg

// [core/tlp_trigger_detect.sv]
// Purpose: Turns a synchronous pin level into a one-cycle trigger pulse.
// Assumes: Pin is synchronous to clk_sys.
// Notes: Low-level mode fires every cycle the pin is low.
`timescale 1ns/1ps
module tlp_trigger_detect
	import tlp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [1:0] mode,
	input wire logic pin,
	output logic fire
);

	logic pin_prev_reg;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev_reg <= 1'b1;
		end else begin
			pin_prev_reg <= pin;
		end
	end

	always_comb begin
		case (mode)
			TRIG_LOW_LEVEL: fire = ~pin;
			TRIG_RISING: fire = pin & ~pin_prev_reg;
			TRIG_FALLING: fire = ~pin & pin_prev_reg;
			TRIG_BOTH: fire = pin ^ pin_prev_reg;
			default: fire = 1'b0;
		endcase
	end

endmodule : tlp_trigger_detect
